// ===== src/rsq_top.sv
// Reset, boot strap capture and aux power timing for a multi-port switch
//
// The AXI4-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module rsq_top
  import rsq_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic FUNDAMENTAL_RESET_N,
  input wire logic COMMON_CLOCK_DOWNSTREAM,
  input wire logic COMMON_CLOCK_UPSTREAM,
  input wire logic MASTER_BUS_SLOW_MODE,
  input wire logic RESET_HALT,
  input wire logic [2:0] SWITCH_OPERATING_MODE,
  input wire logic REFCLK_FREQ_SELECT,
  input wire logic [2:0] EEPROM_BUS_ADDRESS,
  input wire logic AUX_POWER_DISABLE_N,
  input wire logic HOT_RESET_IN,
  output logic CORE_RESET_N,
  output logic [NUM_PORTS-1:0] PORT_RESET_N,
  output logic [NUM_PORTS-1:0] PORT_SOFT_RESET_OUT,
  output logic HOT_RESET_OUT,
  output logic CFG_COMMON_CLK_DS,
  output logic CFG_COMMON_CLK_US,
  output logic [rsq_pkg::RSQ_DIV_W-1:0] MASTER_BUS_DIV,
  output logic [7:0] REFCLK_MHZ,
  output logic EEPROM_LOAD_EN,
  output logic [2:0] EEPROM_ADDR,
  output logic L2_ENABLE,
  output logic AUX_SUPPLY_EN,
  input wire logic [rsq_pkg::RSQ_AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [rsq_pkg::RSQ_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [rsq_pkg::RSQ_AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [rsq_pkg::RSQ_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import rsq_pkg::*;

  if (NUM_PORTS < 1 || NUM_PORTS > RSQ_MAX_PORTS) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 8");
  end
  // Pin synchronisers, first stage feeds only the second; straps reset to defaults
  localparam int SW = RSQ_VEC_W + 3;
  logic [SW-1:0] pin_meta;
  logic [SW-1:0] pin_sync;
  wire [SW-1:0] pin_raw = {HOT_RESET_IN, AUX_POWER_DISABLE_N, FUNDAMENTAL_RESET_N,
    EEPROM_BUS_ADDRESS, REFCLK_FREQ_SELECT, SWITCH_OPERATING_MODE, RESET_HALT,
    MASTER_BUS_SLOW_MODE, COMMON_CLOCK_UPSTREAM, COMMON_CLOCK_DOWNSTREAM};
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pin_meta <= SW'(RSQ_VEC_DEFAULT);
      pin_sync <= SW'(RSQ_VEC_DEFAULT);
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end
  // Raw pin levels are kept: a switch that is on reads as 0
  wire [RSQ_VEC_W-1:0] strap_s = pin_sync[RSQ_VEC_W-1:0];
  wire fund_n = pin_sync[RSQ_VEC_W];
  wire apd_n = pin_sync[RSQ_VEC_W+1];
  wire hot_in = pin_sync[RSQ_VEC_W+2];
  logic fund_q;
  wire rel_pulse = fund_n & ~fund_q;
  // Straps tracked during reset, frozen at its release
  logic [RSQ_VEC_W-1:0] samp;
  logic [RSQ_VEC_W-1:0] vec;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      fund_q <= 1'b0;
      samp <= RSQ_VEC_DEFAULT;
      vec <= RSQ_VEC_DEFAULT;
    end else begin
      fund_q <= fund_n;
      if (!fund_n) samp <= strap_s;
      if (rel_pulse) vec <= samp;
    end
  end

  // Decoded operating parameters
  localparam logic [RSQ_DIV_W-1:0] DIV_SS = RSQ_DIV_W'(RSQ_REF_SLOW_KHZ / RSQ_BUS_SLOW_KHZ);
  localparam logic [RSQ_DIV_W-1:0] DIV_SF = RSQ_DIV_W'(RSQ_REF_SLOW_KHZ / RSQ_BUS_FAST_KHZ);
  localparam logic [RSQ_DIV_W-1:0] DIV_FS = RSQ_DIV_W'(RSQ_REF_FAST_KHZ / RSQ_BUS_SLOW_KHZ);
  localparam logic [RSQ_DIV_W-1:0] DIV_FF = RSQ_DIV_W'(RSQ_REF_FAST_KHZ / RSQ_BUS_FAST_KHZ);
  wire v_slow = vec[RSQ_V_SLOW];
  wire v_fast_ref = vec[RSQ_V_REFCLK];
  wire [2:0] v_mode = vec[RSQ_V_MODE_LSB +: 3];
  wire mode_rsvd = (v_mode != RSQ_MODE_NORMAL) && (v_mode != RSQ_MODE_EEPROM);
  wire [RSQ_DIV_W-1:0] div_sel = v_fast_ref ? (v_slow ? DIV_FS : DIV_FF)
                                            : (v_slow ? DIV_SS : DIV_SF);
  assign CFG_COMMON_CLK_DS = vec[RSQ_V_CCDS];
  assign CFG_COMMON_CLK_US = vec[RSQ_V_CCUS];
  assign MASTER_BUS_DIV = div_sel;
  assign REFCLK_MHZ = v_fast_ref ? RSQ_REF_FAST_MHZ : RSQ_REF_SLOW_MHZ;
  assign EEPROM_LOAD_EN = (v_mode == RSQ_MODE_EEPROM);
  assign EEPROM_ADDR = vec[RSQ_V_ADDR_LSB +: 3];
  // Aux power disable timing; NRST only, so later fundamental resets cannot disturb it
  logic apd_run;
  logic apd_done;
  logic apd_early;
  logic l2_en;
  logic [RSQ_APD_CNT_W-1:0] apd_cnt;
  localparam logic [RSQ_APD_CNT_W-1:0] APD_LAST = RSQ_APD_CNT_W'(RSQ_APD_SAMPLE_CYC - 1);
  localparam logic [RSQ_APD_CNT_W-1:0] APD_LOW = RSQ_APD_CNT_W'(RSQ_APD_LOW_CYC);
  wire apd_hit = apd_run && !apd_done && (apd_cnt == APD_LAST);
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      apd_run <= 1'b0;
      apd_done <= 1'b0;
      apd_early <= 1'b0;
      l2_en <= 1'b0;
      apd_cnt <= '0;
    end else begin
      if (rel_pulse) apd_run <= 1'b1;
      // Count includes the release cycle, so apd_cnt is cycles since release
      if ((apd_run || rel_pulse) && !apd_done) apd_cnt <= apd_cnt + 1'b1;
      // Board released the strap too early; reported, not acted on
      if (apd_run && apd_cnt < APD_LOW && apd_n) apd_early <= 1'b1;
      if (apd_hit) begin
        apd_done <= 1'b1;
        l2_en <= apd_n;
      end
    end
  end
  assign L2_ENABLE = l2_en;
  // Aux supply unused until the strap is known inactive
  assign AUX_SUPPLY_EN = apd_done && l2_en;
  // AXI4-Lite slave: address and data taken in either order
  logic aw_got;
  logic w_got;
  logic [RSQ_AXI_AW-1:0] aw_addr;
  logic [RSQ_DATA_W-1:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [1:0] rresp;
  logic [RSQ_DATA_W-1:0] rdata;
  assign S_AXI_AWREADY = !aw_got && !bvalid;
  assign S_AXI_WREADY = !w_got && !bvalid;
  assign S_AXI_BVALID = bvalid;
  assign S_AXI_BRESP = bresp;
  assign S_AXI_ARREADY = !rvalid;
  assign S_AXI_RVALID = rvalid;
  assign S_AXI_RRESP = rresp;
  assign S_AXI_RDATA = rdata;
  wire wr_go = aw_got && w_got && !bvalid;
  wire wr_ctrl = wr_go && aw_addr[RSQ_AXI_AW-1:2] == RSQ_OFS_CTRL[RSQ_AXI_AW-1:2];
  wire wr_port = wr_go && aw_addr[RSQ_AXI_AW-1:2] == RSQ_OFS_PORT[RSQ_AXI_AW-1:2];
  wire wr_stat = wr_go && aw_addr[RSQ_AXI_AW-1:2] == RSQ_OFS_STAT[RSQ_AXI_AW-1:2];
  wire wr_bad = wr_go && !wr_ctrl && !wr_port && !wr_stat;
  wire ar_go = S_AXI_ARVALID && !rvalid;
  // Control state
  logic halt;
  logic hot_q;
  logic core_n;
  logic [RSQ_MAX_PORTS-1:0] port_sel;
  logic [RSQ_MAX_PORTS-1:0] port_soft;
  wire sw_halt_wr = wr_ctrl && w_strb[0];
  wire sw_hot = sw_halt_wr && w_data[RSQ_CTRL_HOT];
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      bvalid <= 1'b0;
      bresp <= RSQ_RESP_OKAY;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (wr_go) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_bad ? RSQ_RESP_SLVERR : RSQ_RESP_OKAY;
      end else if (bvalid && S_AXI_BREADY) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      halt <= 1'b0;
      port_sel <= '0;
      port_soft <= '0;
    end else begin
      // Strap load at release wins over a software write in the same cycle
      if (rel_pulse) halt <= samp[RSQ_V_HALT];
      else if (sw_halt_wr) halt <= w_data[RSQ_CTRL_HALT];
      if (wr_port && w_strb[0]) port_sel <= w_data[RSQ_PORT_SEL_LSB +: RSQ_MAX_PORTS];
      if (wr_port && w_strb[1]) port_soft <= w_data[RSQ_PORT_SOFT_LSB +: RSQ_MAX_PORTS];
    end
  end

  // Core held in reset during fundamental reset and while halted; bus stays live
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      core_n <= 1'b0;
      hot_q <= 1'b0;
    end else begin
      core_n <= fund_n && !rel_pulse && !halt;
      hot_q <= hot_in || sw_hot;
    end
  end
  assign CORE_RESET_N = core_n;
  assign HOT_RESET_OUT = hot_q;
  // Downstream reset source per port; fundamental reset after NRST
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    assign PORT_SOFT_RESET_OUT[i] = port_soft[i];
    assign PORT_RESET_N[i] = port_sel[i] ? !port_soft[i] : fund_n;
  end
  // Read path
  logic [RSQ_DATA_W-1:0] stat_word;
  always_comb begin
    stat_word = '0;
    stat_word[RSQ_STAT_VEC_LSB +: RSQ_VEC_W] = vec;
    stat_word[RSQ_STAT_HALTED] = halt;
    stat_word[RSQ_STAT_AUX_DONE] = apd_done;
    stat_word[RSQ_STAT_L2_EN] = l2_en;
    stat_word[RSQ_STAT_AUX_EARLY] = apd_early;
    stat_word[RSQ_STAT_IN_RESET] = !core_n;
    stat_word[RSQ_STAT_MODE_RSVD] = mode_rsvd;
  end
  wire [RSQ_AXI_AW-3:0] ar_idx = S_AXI_ARADDR[RSQ_AXI_AW-1:2];
  wire rd_ctrl = ar_idx == RSQ_OFS_CTRL[RSQ_AXI_AW-1:2];
  wire rd_port = ar_idx == RSQ_OFS_PORT[RSQ_AXI_AW-1:2];
  wire rd_stat = ar_idx == RSQ_OFS_STAT[RSQ_AXI_AW-1:2];
  wire [RSQ_DATA_W-1:0] ctrl_word = RSQ_DATA_W'(halt) << RSQ_CTRL_HALT;
  wire [RSQ_DATA_W-1:0] port_word = (RSQ_DATA_W'(port_sel) << RSQ_PORT_SEL_LSB)
                                  | (RSQ_DATA_W'(port_soft) << RSQ_PORT_SOFT_LSB);
  wire [RSQ_DATA_W-1:0] rd_mux = rd_ctrl ? ctrl_word : rd_port ? port_word
                               : rd_stat ? stat_word : '0;
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      rvalid <= 1'b0;
      rresp <= RSQ_RESP_OKAY;
      rdata <= '0;
    end else if (ar_go) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
      rresp <= (rd_ctrl || rd_port || rd_stat) ? RSQ_RESP_OKAY : RSQ_RESP_SLVERR;
    end else if (rvalid && S_AXI_RREADY) begin
      rvalid <= 1'b0;
    end
  end

  // Checks
  property p_samp_track;
    @(posedge CLK) disable iff (!NRST) !fund_n |=> samp == $past(strap_s);
  endproperty
  a_samp_track: assert property (p_samp_track) else $error("strap not sampled");
  property p_vec_hold;
    @(posedge CLK) disable iff (!NRST) (fund_n && fund_q) |=> $stable(vec);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("strap vector moved");
  property p_halt_core;
    @(posedge CLK) disable iff (!NRST) halt |=> !CORE_RESET_N;
  endproperty
  a_halt_core: assert property (p_halt_core) else $error("core ran while halted");
  property p_halt_load;
    @(posedge CLK) disable iff (!NRST) rel_pulse |=> halt == $past(samp[RSQ_V_HALT]);
  endproperty
  a_halt_load: assert property (p_halt_load) else $error("halt strap not loaded");
  property p_halt_exit;
    @(posedge CLK) disable iff (!NRST)
      (sw_halt_wr && !w_data[RSQ_CTRL_HALT] && !rel_pulse) ##1 (fund_n && !halt)
      |=> CORE_RESET_N;
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt not left");
  property p_aux_sample;
    @(posedge CLK) disable iff (!NRST) apd_hit |=> apd_done && L2_ENABLE == $past(apd_n);
  endproperty
  a_aux_sample: assert property (p_aux_sample) else $error("aux strap sample");
  property p_aux_keep;
    @(posedge CLK) disable iff (!NRST) apd_done |=> $stable(L2_ENABLE) && apd_done;
  endproperty
  a_aux_keep: assert property (p_aux_keep) else $error("aux level changed");
  property p_aux_use;
    @(posedge CLK) disable iff (!NRST) !L2_ENABLE |-> !AUX_SUPPLY_EN;
  endproperty
  a_aux_use: assert property (p_aux_use) else $error("aux used while disabled");
  property p_bus_div;
    @(posedge CLK) disable iff (!NRST)
      (!v_slow && !v_fast_ref) |-> MASTER_BUS_DIV == DIV_SF && EEPROM_ADDR == vec[10:8];
  endproperty
  a_bus_div: assert property (p_bus_div) else $error("bus divider wrong");
  property p_port_mux;
    @(posedge CLK) disable iff (!NRST)
      !port_sel[0] |-> PORT_RESET_N[0] == fund_n;
  endproperty
  a_port_mux: assert property (p_port_mux) else $error("port reset source");
  property p_hot;
    @(posedge CLK) disable iff (!NRST) sw_hot |=> HOT_RESET_OUT;
  endproperty
  a_hot: assert property (p_hot) else $error("hot reset not sent");
endmodule : rsq_top

// ===== src/rsq_pkg.sv
// Constants, register map and strap layout for the reset and strap sequencer
package rsq_pkg;
  // AXI4-Lite register map (byte addresses)
  localparam int RSQ_AXI_AW = 4;
  localparam int RSQ_DATA_W = 32;
  localparam logic [RSQ_AXI_AW-1:0] RSQ_OFS_CTRL = 4'h0;
  localparam logic [RSQ_AXI_AW-1:0] RSQ_OFS_PORT = 4'h4;
  localparam logic [RSQ_AXI_AW-1:0] RSQ_OFS_STAT = 4'h8;
  localparam logic [1:0] RSQ_RESP_OKAY = 2'h0;
  localparam logic [1:0] RSQ_RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int RSQ_CTRL_HALT = 0;
  localparam int RSQ_CTRL_HOT = 1;
  // Port register fields: select in low byte, soft reset level in next byte
  localparam int RSQ_PORT_SEL_LSB = 0;
  localparam int RSQ_PORT_SOFT_LSB = 8;
  localparam int RSQ_MAX_PORTS = 8;
  // Status register fields
  localparam int RSQ_STAT_VEC_LSB = 0;
  localparam int RSQ_STAT_HALTED = 16;
  localparam int RSQ_STAT_AUX_DONE = 17;
  localparam int RSQ_STAT_L2_EN = 18;
  localparam int RSQ_STAT_AUX_EARLY = 19;
  localparam int RSQ_STAT_IN_RESET = 20;
  localparam int RSQ_STAT_MODE_RSVD = 21;

  // Boot configuration vector layout
  localparam int RSQ_VEC_W = 11;
  localparam int RSQ_V_CCDS = 0;
  localparam int RSQ_V_CCUS = 1;
  localparam int RSQ_V_SLOW = 2;
  localparam int RSQ_V_HALT = 3;
  localparam int RSQ_V_MODE_LSB = 4;
  localparam int RSQ_V_REFCLK = 7;
  localparam int RSQ_V_ADDR_LSB = 8;
  // Defaults: both common-clock straps set, all else clear
  localparam logic [RSQ_VEC_W-1:0] RSQ_VEC_DEFAULT = 11'h003;

  typedef enum logic [2:0] {
    RSQ_MODE_NORMAL = 3'h0,
    RSQ_MODE_EEPROM = 3'h1
  } rsq_mode_t;

  // Aux power disable timing, in reference clock cycles
  localparam int RSQ_APD_LOW_CYC = 8;
  localparam int RSQ_APD_SAMPLE_CYC = 256;
  localparam int RSQ_APD_CNT_W = 9;

  // Reference clock and master management bus rates
  localparam int RSQ_REF_SLOW_KHZ = 100000;
  localparam int RSQ_REF_FAST_KHZ = 125000;
  localparam int RSQ_BUS_SLOW_KHZ = 100;
  localparam int RSQ_BUS_FAST_KHZ = 400;
  localparam int RSQ_DIV_W = 16;
  localparam logic [7:0] RSQ_REF_SLOW_MHZ = 8'h64;
  localparam logic [7:0] RSQ_REF_FAST_MHZ = 8'h7d;
endpackage : rsq_pkg

// ===== bench/rsq_strap_board.sv
// Model of the board strap switches and the host reset source
`timescale 1ns/1ps
module rsq_strap_board (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [10:0] sw_on,
  input wire logic warm_req,
  input wire logic aux_stuck_low,
  output logic fund_n,
  output logic ccds,
  output logic ccus,
  output logic slow,
  output logic halt,
  output logic [2:0] mode,
  output logic refclk,
  output logic [2:0] addr,
  output logic aux_n
);
  logic [8:0] cnt;
  logic released;
  // Power monitor follows power-on reset; button or host adds a warm reset
  assign fund_n = nrst & ~warm_req;
  // A switch that is on pulls its strap to 0
  assign {addr, refclk, mode, halt, slow, ccus, ccds} = ~sw_on;
  // Saturating count from first release only, so warm resets never restart it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt <= 9'h000;
      released <= 1'b0;
    end else begin
      if (fund_n)
        released <= 1'b1;
      if ((released || fund_n) && cnt != 9'h1ff)
        cnt <= cnt + 9'h001;
    end
  end
  // Low for 8 cycles after release, high long before the 256th
  assign aux_n = ~aux_stuck_low & (cnt >= 9'h008);
endmodule : rsq_strap_board

// ===== bench/rsq_top_test.sv
// Self-checking bench for the reset and strap sequencer
`timescale 1ns/1ps
module rsq_top_test;
  import rsq_pkg::*;
  logic clk, nrst, warm, stuck, hot_in;
  logic [10:0] sw_on, v;
  logic s_ccds, s_ccus, s_slow, s_halt, s_ref, fund_n, aux_n;
  logic [2:0] s_mode, s_addr, eaddr;
  logic core_n, hot_out, ccds_o, ccus_o, load_en, l2, auxen;
  logic [3:0] prst_n, psoft, awaddr, araddr, wstrb;
  logic [15:0] div;
  logic [7:0] mhz;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] wdata, rdata, d;
  logic [10:0] vt [4] = '{11'h003, 11'h516, 11'h2a1, 11'h7f4};
  int err_count, checked, cycles, k, n;

  rsq_strap_board i_board (.clk(clk), .nrst(nrst), .sw_on(sw_on), .warm_req(warm),
    .aux_stuck_low(stuck), .fund_n(fund_n), .ccds(s_ccds), .ccus(s_ccus), .slow(s_slow),
    .halt(s_halt), .mode(s_mode), .refclk(s_ref), .addr(s_addr), .aux_n(aux_n));

  rsq_top i_dut (.CLK(clk), .NRST(nrst), .FUNDAMENTAL_RESET_N(fund_n),
    .COMMON_CLOCK_DOWNSTREAM(s_ccds), .COMMON_CLOCK_UPSTREAM(s_ccus),
    .MASTER_BUS_SLOW_MODE(s_slow), .RESET_HALT(s_halt), .SWITCH_OPERATING_MODE(s_mode),
    .REFCLK_FREQ_SELECT(s_ref), .EEPROM_BUS_ADDRESS(s_addr), .AUX_POWER_DISABLE_N(aux_n),
    .HOT_RESET_IN(hot_in), .CORE_RESET_N(core_n), .PORT_RESET_N(prst_n),
    .PORT_SOFT_RESET_OUT(psoft), .HOT_RESET_OUT(hot_out), .CFG_COMMON_CLK_DS(ccds_o),
    .CFG_COMMON_CLK_US(ccus_o), .MASTER_BUS_DIV(div), .REFCLK_MHZ(mhz),
    .EEPROM_LOAD_EN(load_en), .EEPROM_ADDR(eaddr), .L2_ENABLE(l2), .AUX_SUPPLY_EN(auxen),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task final_report();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : final_report

  // Address and data halves are released independently as each is taken
  task axi_wr(input logic [3:0] a, input logic [31:0] dat, output logic [1:0] resp);
    logic aw_done, w_done;
    @(posedge clk);
    awaddr <= a;
    wdata <= dat;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_done = 1'b0;
    w_done = 1'b0;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task axi_rd(input logic [3:0] a, output logic [31:0] dat, output logic [1:0] resp);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    dat = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Warm reset with new switch settings; straps are taken while it is held
  task boot(input logic [10:0] vec);
    warm <= 1'b1;
    sw_on <= ~vec;
    cyc(6);
    warm <= 1'b0;
    cyc(12);
  endtask : boot

  task power_up(input logic stuck_low);
    nrst <= 1'b0;
    stuck <= stuck_low;
    sw_on <= ~RSQ_VEC_DEFAULT;
    cyc(2);
    nrst <= 1'b1;
    cyc(100);
    chk("aux_en_early", auxen, 0);
    cyc(200);
    chk("l2", l2, !stuck_low);
    chk("aux_en", auxen, !stuck_low);
  endtask : power_up

  // Long enough for every test with a wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    nrst = 1'b0;
    warm = 1'b0;
    stuck = 1'b0;
    hot_in = 1'b0;
    sw_on = ~RSQ_VEC_DEFAULT;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    power_up(1'b0);
    axi_rd(RSQ_OFS_STAT, d, r);
    chk("aux_done", d[RSQ_STAT_AUX_DONE], 1);
    chk("aux_fault", d[RSQ_STAT_AUX_EARLY], 0);
    $display("test aux_power done");
    for (k = 0; k < 4; k++) begin
      v = vt[k];
      boot(v);
      chk("ccds", ccds_o, v[RSQ_V_CCDS]);
      chk("ccus", ccus_o, v[RSQ_V_CCUS]);
      chk("div", div, (v[7] ? RSQ_REF_FAST_KHZ : RSQ_REF_SLOW_KHZ) /
        (v[2] ? RSQ_BUS_SLOW_KHZ : RSQ_BUS_FAST_KHZ));
      chk("mhz", mhz, v[7] ? RSQ_REF_FAST_MHZ : RSQ_REF_SLOW_MHZ);
      chk("load_en", load_en, v[6:4] == RSQ_MODE_EEPROM);
      chk("eaddr", eaddr, v[10:8]);
      chk("core", core_n, 1);
      axi_rd(RSQ_OFS_STAT, d, r);
      chk("stat_vec", d[10:0], v);
      chk("stat_rsvd", d[RSQ_STAT_MODE_RSVD], v[6:4] > 3'h1);
      sw_on <= ~(v ^ 11'h7f7);
      cyc(6);
      chk("held_addr", eaddr, v[10:8]);
      chk("held_ccds", ccds_o, v[RSQ_V_CCDS]);
      chk("l2_kept", l2, 1);
    end
    $display("test boot_vector done");
    warm <= 1'b1;
    cyc(6);
    chk("port_fund", prst_n, 4'h0);
    warm <= 1'b0;
    axi_wr(RSQ_OFS_PORT, 32'h0000_0105, r);
    warm <= 1'b1;
    cyc(6);
    chk("port_mix", prst_n, 4'h4);
    warm <= 1'b0;
    cyc(12);
    chk("port_run", prst_n, 4'he);
    chk("port_soft", psoft, 4'h1);
    axi_rd(RSQ_OFS_PORT, d, r);
    chk("port_reg", d, 32'h0000_0105);
    axi_wr(RSQ_OFS_PORT, 32'h0, r);
    $display("test port_reset done");
    boot(11'h00b);
    chk("halted", core_n, 0);
    axi_rd(RSQ_OFS_CTRL, d, r);
    chk("halt_bit", d[RSQ_CTRL_HALT], 1);
    axi_wr(RSQ_OFS_CTRL, 32'h0, r);
    cyc(4);
    chk("unhalted", core_n, 1);
    axi_wr(RSQ_OFS_CTRL, 32'h1, r);
    axi_rd(RSQ_OFS_CTRL, d, r);
    chk("halt_wr", d[RSQ_CTRL_HALT], 1);
    axi_wr(RSQ_OFS_CTRL, 32'h0, r);
    $display("test halt done");
    axi_wr(RSQ_OFS_CTRL, 32'h2, r);
    n = 0;
    while (hot_out !== 1'b1 && n < 4) begin
      @(posedge clk);
      n++;
    end
    chk("hot_sw", hot_out, 1);
    @(posedge clk);
    chk("hot_pulse", hot_out, 0);
    hot_in <= 1'b1;
    cyc(6);
    chk("hot_in", hot_out, 1);
    hot_in <= 1'b0;
    cyc(6);
    chk("hot_off", hot_out, 0);
    $display("test hot_reset done");
    axi_rd(4'hc, d, r);
    chk("bad_rd", {d[29:0], r}, {30'h0, RSQ_RESP_SLVERR});
    axi_wr(4'hc, 32'h1, r);
    chk("bad_wr", r, RSQ_RESP_SLVERR);
    axi_wr(RSQ_OFS_STAT, 32'hffff_ffff, r);
    chk("stat_wr", r, RSQ_RESP_OKAY);
    axi_rd(RSQ_OFS_STAT, d, r);
    chk("stat_ro", d[10:0], 11'h00b);
    $display("test bus_errors done");
    power_up(1'b1);
    $display("test aux_stuck done");
    final_report();
  end
endmodule : rsq_top_test
